// [shared/ppsi_defines.svh]
// Purpose: offsets, field positions, reset values of the port status/irq block
// Assumes: byte addresses on a 32-bit APB, one aligned word per register
// Notes: included by bare name
`ifndef PPSI_DEFINES_SVH
`define PPSI_DEFINES_SVH

// ==========================================================
// register byte offsets
`define PPSI_OFF_MASK 8'h00
`define PPSI_OFF_STATUS 8'h04
`define PPSI_OFF_DATA 8'h08
`define PPSI_OFF_CTRL 8'h0c

// ==========================================================
// field positions, shared by status and mask, then control bits
`define PPSI_BIT_RECV 0
`define PPSI_BIT_XMIT 1
`define PPSI_BIT_ERROR 3
`define PPSI_BIT_ONLINE 4
`define PPSI_BIT_MEDIA 5
`define PPSI_BIT_HSHAKE 6
`define PPSI_BIT_BUSY 7
`define PPSI_CTRL_BIT_DIR 0
`define PPSI_CTRL_BIT_DMA 1

// ==========================================================
// reset values
`define PPSI_MASK_RST 8'h00
`define PPSI_CTRL_RST 2'h0
`define PPSI_DATA_RST 8'h00
`define PPSI_XMIT_EMPTY_RST 1'b1
`define PPSI_RECV_FULL_RST 1'b0

`endif

// [shared/ppsi_pkg.sv]
// Purpose: types of the port status/irq block
// Assumes: nothing beyond the defines header
// Notes: field order of the packed structs is top bit first, down to bit 0
package ppsi_pkg;

  // ==========================================================
  // status register layout
  typedef struct packed {
    logic busy;
    logic handshake;
    logic media_empty;
    logic online;
    logic error;
    logic rsv2;
    logic xmit_empty_flag;
    logic recv_full_flag;
  } ppsi_status_t;

  // ==========================================================
  // interrupt mask register layout
  typedef struct packed {
    logic rsv7;
    logic handshake_irq_en;
    logic media_empty_irq_en;
    logic rsv4;
    logic error_irq_en;
    logic rsv2;
    logic xmit_empty_irq_en;
    logic recv_full_irq_en;
  } ppsi_mask_t;

  // ==========================================================
  // peripheral handshake pins as they arrive
  typedef struct packed {
    logic busy_in;
    logic handshake_in;
    logic media_empty_in;
    logic online_in;
    logic printer_error_in;
  } ppsi_pins_t;

  // ==========================================================
  // port control register layout
  typedef struct packed {
    logic dma_mode;
    logic port_dir;
  } ppsi_ctrl_t;

endpackage

// [design/ppsi_sync.sv]
// Purpose: two-flop synchroniser for a group of level pins
// Assumes: inputs are asynchronous levels
// Notes: first stage is read by the second stage only
`timescale 1ns/100ps
module ppsi_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) begin
      $error("ppsi_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// [design/ppsi_data_slot.sv]
// Purpose: port data register with its occupancy flags
// Assumes: all strobes come from logic on the same clock
// Notes: a set of a flag wins over a clear in the same cycle
`timescale 1ns/100ps
`include "ppsi_defines.svh"
module ppsi_data_slot (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic port_dir,
  input wire logic sw_write,
  input wire logic [7:0] sw_wdata,
  input wire logic rd_take,
  input wire logic recv_stb,
  input wire logic [7:0] recv_data,
  input wire logic xmit_accept,
  output logic [7:0] data,
  output logic recv_full_flag,
  output logic xmit_empty_flag,
  output logic drive_oe,
  output logic load_pulse
);

  logic load_ok;
  logic recv_ok;

  // a byte is taken only in output direction and only into an empty slot
  assign load_ok = sw_write & ~port_dir & xmit_empty_flag;
  assign recv_ok = recv_stb & port_dir;

  // ==========================================================
  // data byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data <= `PPSI_DATA_RST;
    end else if (load_ok) begin
      data <= sw_wdata;
    end else if (recv_ok) begin
      data <= recv_data;
    end
  end

  // ==========================================================
  // receive-full flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      recv_full_flag <= `PPSI_RECV_FULL_RST;
    end else if (recv_ok) begin
      recv_full_flag <= 1'b1;
    end else if (rd_take) begin
      recv_full_flag <= 1'b0;
    end
  end

  // ==========================================================
  // transmit-empty flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xmit_empty_flag <= `PPSI_XMIT_EMPTY_RST;
    end else if (xmit_accept & ~xmit_empty_flag) begin
      xmit_empty_flag <= 1'b1;
    end else if (load_ok) begin
      xmit_empty_flag <= 1'b0;
    end
  end

  // ==========================================================
  // pin drive and load strobe toward the handshake sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_oe <= 1'b0;
      load_pulse <= 1'b0;
    end else begin
      drive_oe <= ~port_dir;
      load_pulse <= load_ok;
    end
  end

endmodule

// [design/ppsi_top.sv]
// Purpose: status and interrupt-mask logic of a byte-wide parallel port
// Assumes: APB slave on MCLK; handshake sequencer strobes share MCLK
// Notes: peripheral pins are synchronised before use
// Function
// - mask bit 0 lets a set receive-full flag raise the interrupt.
// - mask bit 1 lets a set transmit-empty flag raise the interrupt.
// - mask bits 3, 5, 6 enable fault, paper-end, acknowledge interrupts.
// - a cleared enable blocks its flag; all enables reset to zero.
// - status bit 0 is one while the data register holds a received byte.
// - reading the received byte clears the receive-full flag.
// - receive-full applies in input direction, for processor-driven transfers.
// - status bit 1 resets to one and is one while data register empty.
// - data register occupied while transmit-empty is zero; no new byte then.
// - transmit-empty stays zero after a load until the peripheral accepts.
// - transmit-empty applies in output direction, for processor-driven transfers.
// - status bit 3 is the inverse of the fault pin.
// - status bit 4 follows the select pin.
// - status bit 5 follows the paper-end pin.
// - status bit 6 is the inverse of the acknowledge pin.
// - status bit 7 follows the busy pin.
// - status register read-only in every mode; bit 2 reads zero.
// - direction zero drives the port out; one makes it an input.
// - under DMA, receive-full serves as the input DMA request.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "ppsi_defines.svh"
module ppsi_top
  import ppsi_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic MCLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // peripheral pins, asynchronous
  input wire logic PRINTER_ERROR_IN,
  input wire logic ONLINE_IN,
  input wire logic MEDIA_EMPTY_IN,
  input wire logic HANDSHAKE_IN,
  input wire logic BUSY_IN,
  // handshake sequencer, same clock
  input wire logic RECV_STB,
  input wire logic [7:0] RECV_DATA,
  input wire logic XMIT_ACCEPT,
  input wire logic DMA_RD,
  // outputs
  output logic [7:0] PD_OUT,
  output logic PD_OE,
  output logic XMIT_LOAD,
  output logic PORT_DIR,
  output logic DMA_REQ,
  output logic IRQ
);

  // ==========================================================
  // elaboration check
  initial begin
    if (ADDR_W < 4 || ADDR_W > 32) begin
      $error("ppsi_top: ADDR_W must lie in 4..32");
    end
  end

  // ==========================================================
  // declarations
  ppsi_pins_t pins_raw;
  ppsi_pins_t pins;
  ppsi_mask_t irq_mask_reg;
  ppsi_ctrl_t ctrl_reg;
  ppsi_status_t port_status_reg;
  logic [7:0] mask_wr_bits;
  logic [7:0] port_data_reg;
  logic recv_full_flag;
  logic xmit_empty_flag;
  logic slot_oe;
  logic slot_load;
  logic setup;
  logic done;
  logic hit_mask;
  logic hit_status;
  logic hit_data;
  logic hit_ctrl;
  logic mapped;
  logic sw_data_write;
  logic sw_data_read;
  logic [31:0] next_rdata;
  logic next_irq;

  // ==========================================================
  // pin synchronisation
  assign pins_raw = '{
    busy_in: BUSY_IN,
    handshake_in: HANDSHAKE_IN,
    media_empty_in: MEDIA_EMPTY_IN,
    online_in: ONLINE_IN,
    printer_error_in: PRINTER_ERROR_IN
  };

  ppsi_sync #(
    .WIDTH($bits(ppsi_pins_t))
  ) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .d(pins_raw),
    .q(pins)
  );

  // ==========================================================
  // apb decode
  assign setup = PSEL & ~PENABLE & ~PREADY;
  assign done = PSEL & PENABLE & PREADY;
  assign hit_mask = (PADDR == ADDR_W'(`PPSI_OFF_MASK));
  assign hit_status = (PADDR == ADDR_W'(`PPSI_OFF_STATUS));
  assign hit_data = (PADDR == ADDR_W'(`PPSI_OFF_DATA));
  assign hit_ctrl = (PADDR == ADDR_W'(`PPSI_OFF_CTRL));
  assign mapped = hit_mask | hit_status | hit_data | hit_ctrl;
  assign sw_data_write = done & PWRITE & hit_data;
  assign sw_data_read = done & ~PWRITE & hit_data;

  // one wait-free access phase: ready rises the cycle after setup
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup & ~mapped;
    end
  end

  // ==========================================================
  // read data, captured in the setup cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_mask) begin
      next_rdata = {24'h00_0000, irq_mask_reg};
    end else if (hit_status) begin
      next_rdata = {24'h00_0000, port_status_reg};
    end else if (hit_data) begin
      next_rdata = {24'h00_0000, port_data_reg};
    end else if (hit_ctrl) begin
      next_rdata = {30'h0000_0000, ctrl_reg};
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      PRDATA <= next_rdata;
    end else if (done) begin
      PRDATA <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // interrupt mask register, reserved bits stay zero
  assign mask_wr_bits = (8'h01 << `PPSI_BIT_RECV) | (8'h01 << `PPSI_BIT_XMIT) | (8'h01 << `PPSI_BIT_ERROR)
    | (8'h01 << `PPSI_BIT_MEDIA) | (8'h01 << `PPSI_BIT_HSHAKE);

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      irq_mask_reg <= `PPSI_MASK_RST;
    end else if (done && PWRITE && hit_mask) begin
      irq_mask_reg <= PWDATA[7:0] & mask_wr_bits;
    end
  end

  // ==========================================================
  // control register: direction and dma mode
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl_reg <= `PPSI_CTRL_RST;
    end else if (done && PWRITE && hit_ctrl) begin
      ctrl_reg.port_dir <= PWDATA[`PPSI_CTRL_BIT_DIR];
      ctrl_reg.dma_mode <= PWDATA[`PPSI_CTRL_BIT_DMA];
    end
  end

  // ==========================================================
  // port data register and occupancy
  ppsi_data_slot u_slot (
    .clk(MCLK),
    .rst_n(RST_N),
    .port_dir(ctrl_reg.port_dir),
    .sw_write(sw_data_write),
    .sw_wdata(PWDATA[7:0]),
    .rd_take(sw_data_read | (DMA_RD & ctrl_reg.dma_mode)),
    .recv_stb(RECV_STB),
    .recv_data(RECV_DATA),
    .xmit_accept(XMIT_ACCEPT),
    .data(port_data_reg),
    .recv_full_flag(recv_full_flag),
    .xmit_empty_flag(xmit_empty_flag),
    .drive_oe(slot_oe),
    .load_pulse(slot_load)
  );

  // ==========================================================
  // status register, live view of flags and pins
  always_comb begin
    port_status_reg = '0;
    port_status_reg.recv_full_flag = recv_full_flag;
    port_status_reg.xmit_empty_flag = xmit_empty_flag;
    port_status_reg.rsv2 = 1'b0;
    port_status_reg.error = ~pins.printer_error_in;
    port_status_reg.online = pins.online_in;
    port_status_reg.media_empty = pins.media_empty_in;
    port_status_reg.handshake = ~pins.handshake_in;
    port_status_reg.busy = pins.busy_in;
  end

  // ==========================================================
  // interrupt: each flag gated by its enable
  always_comb begin
    next_irq = (port_status_reg.recv_full_flag & irq_mask_reg.recv_full_irq_en)
      | (port_status_reg.xmit_empty_flag & irq_mask_reg.xmit_empty_irq_en)
      | (port_status_reg.error & irq_mask_reg.error_irq_en)
      | (port_status_reg.media_empty & irq_mask_reg.media_empty_irq_en)
      | (port_status_reg.handshake & irq_mask_reg.handshake_irq_en);
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= next_irq;
    end
  end

  // ==========================================================
  // dma request, input direction only
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      DMA_REQ <= 1'b0;
    end else begin
      DMA_REQ <= recv_full_flag & ctrl_reg.port_dir & ctrl_reg.dma_mode & ~(DMA_RD & DMA_REQ);
    end
  end

  // ==========================================================
  // outputs toward pins and sequencer
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PORT_DIR <= 1'b0;
    end else begin
      PORT_DIR <= ctrl_reg.port_dir;
    end
  end

  assign PD_OUT = port_data_reg;
  assign PD_OE = slot_oe;
  assign XMIT_LOAD = slot_load;

endmodule

// [test/ppsi_top_asserts.sv]
// Purpose: concurrent checks on the port status/irq block ports
// Assumes: single clock MCLK, synchronous active-low RST_N
// Notes: bound to ppsi_top below
`timescale 1ns/100ps
module ppsi_top_asserts
  import ppsi_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic PRINTER_ERROR_IN,
  input wire logic ONLINE_IN,
  input wire logic MEDIA_EMPTY_IN,
  input wire logic HANDSHAKE_IN,
  input wire logic BUSY_IN,
  input wire logic DMA_RD,
  input wire logic PD_OE,
  input wire logic XMIT_LOAD,
  input wire logic PORT_DIR,
  input wire logic DMA_REQ,
  input wire logic IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // ========
  // pin quiet counter
  wire logic [4:0] pins = {BUSY_IN, HANDSHAKE_IN, MEDIA_EMPTY_IN, ONLINE_IN, PRINTER_ERROR_IN};
  wire logic wr_data = PSEL && PENABLE && PREADY && PWRITE && PADDR[7:0] == 8'h08;
  logic [4:0] pins_q;
  logic [2:0] quiet;
  always_ff @(posedge MCLK) begin
    pins_q <= pins;
  end
  always_ff @(posedge MCLK) begin
    if (!RST_N || pins != pins_q) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  // ========
  // apb phases
  sequence s_setup;
    PSEL && !PENABLE && !PREADY;
  endsequence
  sequence s_access;
    PSEL && PENABLE && PREADY;
  endsequence
  sequence s_stat_rd;
    s_setup ##0 (!PWRITE && PADDR[7:0] == 8'h04);
  endsequence
  // ========
  // checks
  chk_ready_pulse: assert property (s_setup |=> PREADY ##1 !PREADY)
    else $error("ready not a single access cycle");
  chk_unmapped_err: assert property (s_setup ##0 (PADDR[7:0] > 8'h0c || PADDR[1:0] != 2'h0)
    |=> PSLVERR && PRDATA == 32'h0) else $error("unmapped access not refused");
  chk_status_rsv: assert property (s_stat_rd |=> PRDATA[31:8] == 24'h0 && !PRDATA[2])
    else $error("status reserved bits not zero");
  chk_status_pins: assert property (s_stat_rd ##0 quiet >= 3'h3
    |=> PRDATA[7:3] == ($past(pins, 2) ^ 5'h09)) else $error("status pin bits wrong");
  chk_load_pulse: assert property (XMIT_LOAD |-> $past(wr_data) ##1 !XMIT_LOAD)
    else $error("load pulse without data write");
  chk_mask_off_irq: assert property (s_access ##0 (PWRITE && PADDR[7:0] == 8'h00 && PWDATA[7:0] == 8'h00)
    |=> ##1 !IRQ [*2]) else $error("irq with all sources masked");
  chk_oe_dir: assert property ($stable(PORT_DIR) [*3] |-> PD_OE == !PORT_DIR)
    else $error("drive enable disagrees with direction");
  chk_dma_drop: assert property (DMA_RD && DMA_REQ |=> !DMA_REQ)
    else $error("dma request held after dma read");
endmodule

bind ppsi_top ppsi_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PRINTER_ERROR_IN(PRINTER_ERROR_IN), .ONLINE_IN(ONLINE_IN),
  .MEDIA_EMPTY_IN(MEDIA_EMPTY_IN), .HANDSHAKE_IN(HANDSHAKE_IN), .BUSY_IN(BUSY_IN), .DMA_RD(DMA_RD),
  .PD_OE(PD_OE), .XMIT_LOAD(XMIT_LOAD), .PORT_DIR(PORT_DIR), .DMA_REQ(DMA_REQ), .IRQ(IRQ));

// [test/ppsi_printer_model.sv]
// Purpose: behavioural printer on the far side of the port
// Assumes: strobes share the system clock
// Notes: accept delay set by the bench; idle receive data toggles
`timescale 1ns/100ps
module ppsi_printer_model
  import ppsi_pkg::*;
(
  input wire logic clk,
  input wire logic xmit_load,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe,
  input wire logic [3:0] accept_lat,
  input wire logic send_go,
  input wire logic [7:0] send_byte,
  output logic recv_stb = 1'b0,
  output logic [7:0] recv_data = 8'h00,
  output logic xmit_accept = 1'b0,
  output logic [7:0] last_rx = 8'h00
);
  logic busy = 1'b0;
  logic [3:0] wait_cnt = 4'h0;
  // ========
  // take the byte after a delay, then acknowledge
  always_ff @(posedge clk) begin
    xmit_accept <= 1'b0;
    if (xmit_load) begin
      busy <= 1'b1;
      wait_cnt <= accept_lat;
    end else if (busy && wait_cnt == 4'h0 && pd_oe) begin
      busy <= 1'b0;
      xmit_accept <= 1'b1;
      last_rx <= pd_out;
    end else if (busy && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
  // ========
  // send a byte on request, junk otherwise
  always_ff @(posedge clk) begin
    recv_stb <= send_go;
    recv_data <= send_go ? send_byte : ~recv_data;
  end
endmodule

// [test/parallel_port_status_irq_bench.sv]
// Purpose: self-checking bench of the port status/irq block
// Assumes: APB master in this module, printer model on the far side
// Notes: pin cases run from a table, the rest by hand
`timescale 1ns/100ps
`include "ppsi_defines.svh"
module parallel_port_status_irq_bench;
  import ppsi_pkg::*;
  typedef struct packed {
    logic [4:0] p;
    logic [4:0] st;
    logic irq;
  } ppsi_row_t;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dma_rd = 1'b0;
  logic [7:0] paddr = 8'h00, pd_out, recv_data, last_rx, send_byte = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, recv_stb, xmit_accept, pd_oe, xmit_load, port_dir, dma_req, irq, err, send_go = 1'b0;
  ppsi_pins_t pins = 5'b10000;
  logic [3:0] accept_lat = 4'hf;
  int miscompares = 0, samples_checked = 0;
  ppsi_row_t rows [7] = '{{5'b01001, 5'b00000, 1'b0}, {5'b10000, 5'b11001, 1'b1}, {5'b01011, 5'b00010, 1'b0},
    {5'b01101, 5'b00100, 1'b1}, {5'b00001, 5'b01000, 1'b1}, {5'b01000, 5'b00001, 1'b1},
    {5'b11001, 5'b10000, 1'b0}};
  always #4 mclk = ~mclk;
  ppsi_top dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PRINTER_ERROR_IN(pins.printer_error_in),
    .ONLINE_IN(pins.online_in), .MEDIA_EMPTY_IN(pins.media_empty_in), .HANDSHAKE_IN(pins.handshake_in),
    .BUSY_IN(pins.busy_in), .RECV_STB(recv_stb), .RECV_DATA(recv_data), .XMIT_ACCEPT(xmit_accept),
    .DMA_RD(dma_rd), .PD_OUT(pd_out), .PD_OE(pd_oe), .XMIT_LOAD(xmit_load), .PORT_DIR(port_dir),
    .DMA_REQ(dma_req), .IRQ(irq));
  ppsi_printer_model u_prn (.clk(mclk), .xmit_load(xmit_load), .pd_out(pd_out), .pd_oe(pd_oe),
    .accept_lat(accept_lat), .send_go(send_go), .send_byte(send_byte), .recv_stb(recv_stb),
    .recv_data(recv_data), .xmit_accept(xmit_accept), .last_rx(last_rx));
  // ========
  // tasks
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic send(input logic [7:0] b);
    send_go <= 1'b1;
    send_byte <= b;
    @(posedge mclk);
    send_go <= 1'b0;
    cyc(3);
  endtask
  // ========
  // main sequence
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(4);
    apb(1'b0, `PPSI_OFF_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `PPSI_OFF_STATUS, 32'hff);
    apb(1'b0, `PPSI_OFF_STATUS, 32'h0);
    chk(rd, 32'hca);
    chk(32'(irq), 32'h0);
    apb(1'b1, `PPSI_OFF_MASK, 32'hff);
    apb(1'b0, `PPSI_OFF_MASK, 32'h0);
    chk(rd, 32'h6b);
    apb(1'b1, `PPSI_OFF_MASK, 32'h68);
    foreach (rows[i]) begin
      pins <= rows[i].p;
      cyc(4);
      apb(1'b0, `PPSI_OFF_STATUS, 32'h0);
      chk(rd, {24'h0, rows[i].st, 3'b010});
      chk(32'(irq), 32'(rows[i].irq));
    end
    pins <= 5'b01001;
    apb(1'b1, `PPSI_OFF_MASK, 32'h02);
    apb(1'b1, `PPSI_OFF_CTRL, 32'h0);
    chk(32'(irq), 32'h1);
    apb(1'b1, `PPSI_OFF_DATA, 32'ha5);
    chk(32'(pd_out), 32'ha5);
    apb(1'b0, `PPSI_OFF_STATUS, 32'h0);
    chk(32'(rd[1]), 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'b1, `PPSI_OFF_DATA, 32'h3c);
    chk(32'(pd_out), 32'ha5);
    for (int n = 0; n < 40 && irq !== 1'b1; n++) @(posedge mclk);
    chk(32'(last_rx), 32'ha5);
    chk(32'(irq), 32'h1);
    accept_lat <= 4'h0;
    apb(1'b1, `PPSI_OFF_DATA, 32'h3c);
    cyc(4);
    chk(32'(last_rx), 32'h3c);
    apb(1'b1, `PPSI_OFF_MASK, 32'h01);
    send(8'h11);
    apb(1'b0, `PPSI_OFF_STATUS, 32'h0);
    chk(32'(rd[0]), 32'h0);
    apb(1'b1, `PPSI_OFF_CTRL, 32'h1);
    cyc(2);
    chk(32'(pd_oe), 32'h0);
    chk(32'(port_dir), 32'h1);
    send(8'h5a);
    chk(32'(irq), 32'h1);
    apb(1'b0, `PPSI_OFF_STATUS, 32'h0);
    chk(32'(rd[0]), 32'h1);
    apb(1'b0, `PPSI_OFF_DATA, 32'h0);
    chk(rd, 32'h5a);
    cyc(2);
    chk(32'(irq), 32'h0);
    apb(1'b1, `PPSI_OFF_MASK, 32'h0);
    apb(1'b1, `PPSI_OFF_CTRL, 32'h3);
    send(8'h77);
    chk(32'(dma_req), 32'h1);
    dma_rd <= 1'b1;
    @(posedge mclk);
    dma_rd <= 1'b0;
    cyc(2);
    chk(32'(dma_req), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    tally_and_finish();
  end
endmodule
